//--- inc/pbsp_consts.svh
`ifndef PBSP_CONSTS_SVH
`define PBSP_CONSTS_SVH

// Array geometry
`define PBSP_ADDR_W 17
`define PBSP_DATA_W 32
`define PBSP_DEPTH 131072
`define PBSP_BURST_W 2

// Field positions inside the word address
`define PBSP_BURST_LSB 0
`define PBSP_BURST_MSB 1
`define PBSP_ROW_LSB 2
`define PBSP_ROW_MSB 16

// Burst-order strap levels
`define PBSP_ORDER_LINEAR 1'b0
`define PBSP_ORDER_INTERLEAVED 1'b1

// Reset values
`define PBSP_RST_ROW 15'h0000
`define PBSP_RST_BURST 2'h0
`define PBSP_RST_WORD 32'h0000_0000
`define PBSP_RST_ADDR 17'h0_0000
`define PBSP_RST_BIT 1'b0

// Burst step
`define PBSP_BURST_STEP 2'h1

`endif

//--- inc/pbsp_pkg.sv
package pbsp_pkg;

	// Synchronous control pins sampled at each rising edge
	typedef struct packed {
		logic proc_addr_strobe_n;
		logic ctrl_addr_strobe_n;
		logic burst_advance_n;
		logic chip_sel_a_n;
		logic chip_sel_b;
		logic chip_sel_c_n;
		logic write_n;
		logic [16:0] addr;
	} pbsp_ctrl_type;

	// Data pin pair: output word and enable
	typedef struct packed {
		logic [31:0] dout;
		logic oe;
	} pbsp_dq_out_type;

	typedef enum logic [0:0] {
		PBSP_ST_IDLE,
		PBSP_ST_ACTIVE
	} pbsp_state_type;

endpackage : pbsp_pkg

//--- src/pbsp_burst_ctr.sv
`timescale 1ns/1ps
`include "pbsp_consts.svh"

module pbsp_burst_ctr (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Control
	input wire logic load,
	input wire logic advance,
	input wire logic interleave,
	input wire logic [1:0] start_bits,
	// Result
	output logic [1:0] burst_bits
);

	logic [1:0] base_reg;
	logic [1:0] base_next;
	logic [1:0] count_reg;
	logic [1:0] count_next;

	always_comb begin
		base_next = base_reg;
		count_next = count_reg;
		if (load) begin
			base_next = start_bits;
			count_next = `PBSP_RST_BURST;
		end else if (advance) begin
			count_next = count_reg + `PBSP_BURST_STEP;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			base_reg <= `PBSP_RST_BURST;
			count_reg <= `PBSP_RST_BURST;
		end else begin
			base_reg <= base_next;
			count_reg <= count_next;
		end
	end

	// Two-bit arithmetic wraps 11 back to 00 by itself
	always_comb begin
		if (interleave) begin
			burst_bits = base_reg ^ count_reg;
		end else begin
			burst_bits = base_reg + count_reg;
		end
	end

endmodule : pbsp_burst_ctr

//--- src/pbsp_sram_port.sv
`timescale 1ns/1ps
`include "pbsp_consts.svh"

module pbsp_sram_port (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Synchronous bus from the controller
	input wire pbsp_pkg::pbsp_ctrl_type ctrl,
	// Asynchronous pins
	input wire logic oe_n,
	input wire logic sleep_req,
	input wire logic burst_order_strap,
	// Data pins
	input wire logic [31:0] dq_i,
	output logic [31:0] dq_o,
	output logic dq_oe,
	// Status
	output logic sleep_active
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic chip_on(input pbsp_pkg::pbsp_ctrl_type c);
		chip_on = !c.chip_sel_a_n && c.chip_sel_b && !c.chip_sel_c_n;
	endfunction : chip_on

	function automatic logic proc_taken(input pbsp_pkg::pbsp_ctrl_type c);
		proc_taken = !c.proc_addr_strobe_n && !c.chip_sel_a_n;
	endfunction : proc_taken

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic sleep_meta_reg;
	logic sleep_sync_reg;
	logic mode_reg;
	logic mode_next;
	logic mode_taken_reg;
	logic mode_taken_next;
	pbsp_pkg::pbsp_state_type state_reg;
	pbsp_pkg::pbsp_state_type state_next;
	logic [14:0] row_reg;
	logic [14:0] row_next;
	logic [31:0] dout_reg;
	logic [31:0] dout_next;
	logic valid_reg;
	logic valid_next;
	logic [31:0] din_reg;
	logic [31:0] din_next;
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [16:0] wr_addr_reg;
	logic [16:0] wr_addr_next;
	logic [31:0] mem [0:`PBSP_DEPTH-1];

	logic awake;
	logic sel_now;
	logic proc_take;
	logic ctrl_take;
	logic strobe;
	logic start;
	logic desel;
	logic active;
	logic wr_now;
	logic advance;
	logic [1:0] burst_bits;
	logic [16:0] cur_addr;

	////////////////////////////////////////////////////////////////////////////////
	// Sleep input synchroniser

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sleep_meta_reg <= `PBSP_RST_BIT;
			sleep_sync_reg <= `PBSP_RST_BIT;
		end else begin
			sleep_meta_reg <= sleep_req;
			sleep_sync_reg <= sleep_meta_reg;
		end
	end

	assign awake = !sleep_sync_reg;
	assign sleep_active = sleep_sync_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Burst-order strap, caught once after reset release

	always_comb begin
		mode_next = mode_reg;
		mode_taken_next = 1'b1;
		if (!mode_taken_reg) begin
			mode_next = burst_order_strap;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= `PBSP_ORDER_INTERLEAVED;
			mode_taken_reg <= `PBSP_RST_BIT;
		end else begin
			mode_reg <= mode_next;
			mode_taken_reg <= mode_taken_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe decode

	always_comb begin
		sel_now = chip_on(ctrl);
		proc_take = proc_taken(ctrl);
		ctrl_take = !ctrl.ctrl_addr_strobe_n && !proc_take;
		strobe = awake && (proc_take || ctrl_take);
		start = strobe && sel_now;
		desel = strobe && !sel_now;
		active = awake && (state_reg == pbsp_pkg::PBSP_ST_ACTIVE);
		// Processor-strobe cycles ignore the write pin; controller ones honour it
		wr_now = !ctrl.write_n && ((start && ctrl_take) || (active && !strobe));
		advance = active && !strobe && !ctrl.burst_advance_n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Burst counter

	pbsp_burst_ctr u_burst (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.load(start),
		.advance(advance),
		.interleave(mode_reg == `PBSP_ORDER_INTERLEAVED),
		.start_bits(ctrl.addr[`PBSP_BURST_MSB:`PBSP_BURST_LSB]),
		.burst_bits(burst_bits)
	);

	assign cur_addr = {row_reg, burst_bits};

	////////////////////////////////////////////////////////////////////////////////
	// Access state and address register

	always_comb begin
		state_next = state_reg;
		row_next = row_reg;
		if (!awake) begin
			state_next = pbsp_pkg::PBSP_ST_IDLE;
		end else begin
			case (state_reg)
				pbsp_pkg::PBSP_ST_IDLE: begin
					if (start) begin
						state_next = pbsp_pkg::PBSP_ST_ACTIVE;
					end
				end
				pbsp_pkg::PBSP_ST_ACTIVE: begin
					if (desel) begin
						state_next = pbsp_pkg::PBSP_ST_IDLE;
					end
				end
				default: begin
					state_next = pbsp_pkg::PBSP_ST_IDLE;
				end
			endcase
			if (start) begin
				row_next = ctrl.addr[`PBSP_ROW_MSB:`PBSP_ROW_LSB];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= pbsp_pkg::PBSP_ST_IDLE;
			row_reg <= `PBSP_RST_ROW;
		end else begin
			state_reg <= state_next;
			row_reg <= row_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read pipeline

	always_comb begin
		dout_next = dout_reg;
		valid_next = `PBSP_RST_BIT;
		if (active && !wr_now && !desel) begin
			// The word addressed at the previous edge moves into the output register
			dout_next = mem[cur_addr];
			valid_next = 1'b1;
		end
		// From idle the valid flag stays low, masking the first read clock
		if (!active) begin
			valid_next = `PBSP_RST_BIT;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dout_reg <= `PBSP_RST_WORD;
			valid_reg <= `PBSP_RST_BIT;
		end else begin
			dout_reg <= dout_next;
			valid_reg <= valid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output drivers

	always_comb begin
		dq_o = dout_reg;
		dq_oe = !oe_n && valid_reg && awake;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input data register and write path

	always_comb begin
		din_next = din_reg;
		if (!dq_oe) begin
			din_next = dq_i;
		end
		wr_pend_next = wr_now;
		wr_addr_next = wr_addr_reg;
		if (wr_now) begin
			wr_addr_next = start ? ctrl.addr : cur_addr;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			din_reg <= `PBSP_RST_WORD;
			wr_pend_reg <= `PBSP_RST_BIT;
			wr_addr_reg <= `PBSP_RST_ADDR;
		end else begin
			din_reg <= din_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
		end
	end

	// Array has no reset; a pending write completes even when sleep arrives
	always_ff @(posedge clk_sys) begin
		if (wr_pend_reg) begin
			mem[wr_addr_reg] <= din_reg;
		end
	end

endmodule : pbsp_sram_port

//--- testbench/pbsp_sram_port_props.sv
`timescale 1ns/1ps
module pbsp_port_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Pins
	input wire pbsp_pkg::pbsp_ctrl_type ctrl,
	input wire logic oe_n,
	input wire logic sleep_req,
	input wire logic dq_oe,
	input wire logic sleep_active
);
	wire logic ps = !ctrl.proc_addr_strobe_n && !ctrl.chip_sel_a_n;
	wire logic stb = ps || !ctrl.ctrl_addr_strobe_n;
	wire logic sel = !ctrl.chip_sel_a_n && ctrl.chip_sel_b && !ctrl.chip_sel_c_n;
	wire logic awake = !sleep_req && !sleep_active;
	wire logic desel = stb && !sel;
	wire logic rd = stb && sel && (ps || ctrl.write_n) && awake;
	wire logic ign = !ctrl.proc_addr_strobe_n && ctrl.chip_sel_a_n && ctrl.ctrl_addr_strobe_n;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	AST_OE_OFF: assert property (oe_n |-> !dq_oe) else $error("driven while disabled");
	AST_SLEEP_FLOAT: assert property (sleep_active |-> !dq_oe) else $error("driven in sleep");
	AST_SLEEP_ON: assert property (sleep_req [*4] |-> sleep_active) else $error("sleep late");
	AST_DESEL: assert property (desel |=> !dq_oe) else $error("driven after deselect");
	AST_FIRST_MASK: assert property (desel ##1 rd |=> !dq_oe) else $error("first read unmasked");
	AST_PROC_IGN: assert property (dq_oe && ign && ctrl.write_n |=> oe_n || sleep_active || dq_oe)
		else $error("strobe not ignored");
	AST_WR_FLOAT: assert property (stb && sel && !ps && !ctrl.write_n |=> !dq_oe) else $error("driven on write");
	AST_READ_OE: assert property (rd ##1 (!stb && ctrl.write_n && awake) ##1 !oe_n |-> dq_oe)
		else $error("read not driven");
endmodule : pbsp_port_chk

bind pbsp_sram_port pbsp_port_chk u_chk (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.ctrl(ctrl),
	.oe_n(oe_n),
	.sleep_req(sleep_req),
	.dq_oe(dq_oe),
	.sleep_active(sleep_active)
);

//--- testbench/pbsp_ctrl_model.sv
`timescale 1ns/1ps
module pbsp_ctrl_model (
	// Clock
	input wire logic clk_sys,
	// Bus toward the port
	output pbsp_pkg::pbsp_ctrl_type ctrl,
	output logic oe_n,
	output logic burst_order_strap,
	// Data pins
	output logic [31:0] dq_i,
	input wire logic [31:0] dq_o,
	input wire logic dq_oe
);
	logic [31:0] wd = 32'h0;
	logic drv = 1'b0;
	logic [31:0] last = 32'h0;
	initial begin
		ctrl = 24'hf60000;
		oe_n = 1'b1;
	end
	// Released pins toggle so stale data never passes for a value
	assign dq_i = dq_oe ? dq_o : (drv ? wd : ~last);
	always @(posedge clk_sys) begin
		last <= dq_i;
	end
	// Strap moves only while the port is in reset
	task automatic strap(input logic s);
		burst_order_strap = s;
	endtask : strap
	task automatic put(input pbsp_pkg::pbsp_ctrl_type c, input logic o, input logic [31:0] d, input logic v);
		@(posedge clk_sys);
		#1;
		ctrl = c;
		oe_n = o;
		wd = d;
		drv = v;
	endtask : put
endmodule : pbsp_ctrl_model

//--- testbench/pbsp_sram_port_test.sv
`timescale 1ns/1ps
module pbsp_sram_port_test;
	logic clk_sys;
	logic arst_n;
	logic sleep_req;
	pbsp_pkg::pbsp_ctrl_type ctrl;
	logic oe_n;
	logic strap;
	logic [31:0] dq_i;
	logic [31:0] dq_o;
	logic dq_oe;
	logic sleep_active;
	logic [31:0] mem [int];
	logic [16:0] a;
	logic [1:0] st;
	logic o;
	int failures;
	int samples_checked;
	int seed;
	pbsp_sram_port DUT (.clk_sys(clk_sys), .arst_n(arst_n), .ctrl(ctrl), .oe_n(oe_n), .sleep_req(sleep_req),
		.burst_order_strap(strap), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .sleep_active(sleep_active));
	pbsp_ctrl_model m (.clk_sys(clk_sys), .ctrl(ctrl), .oe_n(oe_n), .burst_order_strap(strap),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chkw(input logic [31:0] g, input logic [31:0] e);
		// Let the output enable path settle after the pins move
		#1;
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chkw
	task automatic chkf(input logic g, input logic e);
		chkw({31'h0, g}, {31'h0, e});
	endtask : chkf
	task automatic test_done;
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	// One cycle of pin code b at address a, no write data
	task automatic p(input logic [6:0] b, input logic ob);
		m.put({b, a}, ob, 32'h0, 1'b0);
	endtask : p
	// Read of a from idle: masked first cycle, then the stored word
	task automatic rd_a;
		p(7'h55, 1'b0);
		p(7'h7b, 1'b0);
		chkf(dq_oe, 1'b0);
		p(7'h7b, 1'b0);
		chkw(dq_o, mem[int'(a)]);
	endtask : rd_a
	////////////////////////////////
	initial begin
		seed = 32'h6695;
		failures = 0;
		samples_checked = 0;
		sleep_req = 1'b0;
		for (int s = 0; s < 2; s++) begin
			arst_n = 1'b0;
			m.strap(s[0]);
			repeat (2) @(posedge clk_sys);
			#1;
			arst_n = 1'b1;
			a = 17'($random(seed)) & 17'h1fffc;
			for (int i = 0; i < 4; i++) begin
				mem[int'(a) + i] = $random(seed);
				m.put({7'h54, a + 17'(i)}, 1'b1, mem[int'(a) + i], 1'b1);
			end
			// Odd start words make the two burst orders differ
			st = 2'($random(seed)) | 2'h1;
			p(7'h7b, 1'b1);
			m.put({s ? 7'h14 : 7'h55, a | 17'(st)}, 1'b0, 32'h0, 1'b0);
			p(7'h6b, 1'b0);
			chkf(dq_oe, 1'b1);
			for (int i = 0; i < 4; i++) begin
				o = 1'($random(seed));
				p(7'h6b, o);
				chkw(dq_o, mem[int'(a) + (s ? (st ^ i) : ((st + i) % 4))]);
				chkf(dq_oe, !o);
			end
			$display("burst order %0d done", s);
		end
		p(7'h57, 1'b0);
		p(7'h3d, 1'b0);
		chkf(dq_oe, 1'b0);
		p(7'h57, 1'b0);
		chkf(dq_oe, 1'b0);
		rd_a;
		p(7'h2d, 1'b0);
		p(7'h7b, 1'b0);
		chkf(dq_oe, 1'b1);
		p(7'h7b, 1'b0);
		chkw(dq_o, mem[int'(a) + 1]);
		$display("deselect done");
		sleep_req = 1'b1;
		repeat (4) p(7'h55, 1'b0);
		chkf(sleep_active, 1'b1);
		chkf(dq_oe, 1'b0);
		sleep_req = 1'b0;
		repeat (3) p(7'h7b, 1'b0);
		rd_a;
		$display("sleep done");
		test_done;
	end
endmodule : pbsp_sram_port_test
